/* File: wwrc_top.sv */
// window watchdog, reset and mode controller
`timescale 1ns/10ps
module wwrc_top #(
    parameter int unsigned INIT_WINDOW = wwrc_pkg::WWRC_INIT_WINDOW,
    parameter int unsigned CLOSED_WINDOW = wwrc_pkg::WWRC_CLOSED_WINDOW,
    parameter int unsigned OPEN_WINDOW = wwrc_pkg::WWRC_OPEN_WINDOW,
    parameter int unsigned RESET_PULSE = wwrc_pkg::WWRC_RESET_PULSE,
    parameter int unsigned STARTUP = wwrc_pkg::WWRC_STARTUP,
    parameter int unsigned SLEEP_WAKE = wwrc_pkg::WWRC_SLEEP_WAKE,
    parameter int unsigned STANDBY_WAKE = wwrc_pkg::WWRC_STANDBY_WAKE
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire wwrc_pkg::wwrc_cmd_t cmd,
    input wire logic [7:0] meas_in,
    input wire logic meas_load,
    input wire logic [7:0] voltage_err,
    input wire logic cs_n_pin,
    input wire logic miso_data,
    output logic host_reset_out,
    output logic data_ready_out,
    output logic sleep_n_out,
    output logic miso_o,
    output logic miso_oe,
    output logic [7:0] status_flags,
    output logic [7:0] meas_data,
    output logic [7:0] fault_reg,
    output logic [7:0] user_settings,
    output logic blocks_enable
);

    localparam int unsigned W = wwrc_pkg::WWRC_CNT_W;

    // ************************************************************
    // pin synchroniser for chip select
    // ************************************************************
    logic cs_meta; // first stage, read only by cs_sync
    logic cs_sync; // second stage, safe to use

    // two flops before any logic sees chip select
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
        end else begin
            cs_meta <= cs_n_pin;
            cs_sync <= cs_meta;
        end
    end

    // release miso whenever chip select is high
    assign miso_oe = ~cs_sync;
    assign miso_o = miso_data & ~cs_sync;

    // ************************************************************
    // command decode
    // ************************************************************
    wwrc_pkg::wwrc_mode_t mode; // current operating mode
    wwrc_pkg::wwrc_wd_t wd_state; // current watchdog window
    logic [W-1:0] wd_cnt; // cycles left in the window
    logic [W-1:0] pulse_cnt; // cycles left of host reset pulse
    logic [W-1:0] ready_cnt; // cycles left before ready rises

    wire in_sleep = (mode == wwrc_pkg::WWRC_SLEEP);
    wire sleep_cmd = cmd.sleep_enter_variant_a | cmd.sleep_enter_variant_b;
    wire stby_cmd = cmd.standby_enter_variant_a
        | cmd.standby_enter_variant_b;
    // flags follow the same priority as the mode register
    wire sleep_win = sleep_cmd & ~cmd.soft_reset & ~cmd.normal_run;
    wire stby_win = stby_cmd & ~sleep_cmd & ~cmd.soft_reset
        & ~cmd.normal_run;
    wire wake_sleep = cmd.normal_run & in_sleep;
    wire wake_stby = cmd.normal_run & (mode == wwrc_pkg::WWRC_STANDBY);
    // restarts in sleep are refused and flagged
    wire restart_live = cmd.restart & ~in_sleep;
    wire restart_bad = cmd.restart & in_sleep;
    wire window_end = (wd_cnt == W'(1));
    wire wd_is_closed = (wd_state == wwrc_pkg::WWRC_WD_CLOSED);
    // restart refused in the closed window
    wire closed_hit = restart_live & wd_is_closed;
    // expiry of an open window without restart
    wire open_expire = ~in_sleep & window_end & ~wd_is_closed
        & ~restart_live;
    // one trip however many causes coincide
    wire wd_trip = closed_hit | open_expire;
    wire ok_restart = restart_live & ~wd_is_closed;

    // ************************************************************
    // watchdog window machine
    // ************************************************************
    // soft reset and standby moves leave this machine alone
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wd_state <= wwrc_pkg::WWRC_WD_INIT;
            wd_cnt <= W'(INIT_WINDOW);
        end else if (wd_trip || wake_sleep) begin
            // reload the initial window once
            wd_state <= wwrc_pkg::WWRC_WD_INIT;
            wd_cnt <= W'(INIT_WINDOW);
        end else if (in_sleep) begin
            // frozen while disabled
            wd_cnt <= wd_cnt;
        end else if (ok_restart || (wd_is_closed && window_end)) begin
            // restart or closed window over
            wd_state <= ok_restart ? wwrc_pkg::WWRC_WD_CLOSED
                : wwrc_pkg::WWRC_WD_OPEN;
            wd_cnt <= ok_restart ? W'(CLOSED_WINDOW) : W'(OPEN_WINDOW);
        end else begin
            wd_cnt <= wd_cnt - W'(1);
        end
    end

    // ************************************************************
    // host reset pulse
    // ************************************************************
    // low for the pulse time after a trip, idle high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pulse_cnt <= '0;
        end else if (wd_trip && pulse_cnt == '0) begin
            pulse_cnt <= W'(RESET_PULSE);
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - W'(1);
        end
    end

    assign host_reset_out = (pulse_cnt == '0);

    // ************************************************************
    // operating mode
    // ************************************************************
    // soft reset returns to run; mode commands move the state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode <= wwrc_pkg::WWRC_RUN;
        end else if (cmd.soft_reset || cmd.normal_run) begin
            mode <= wwrc_pkg::WWRC_RUN;
        end else if (sleep_cmd) begin
            mode <= wwrc_pkg::WWRC_SLEEP;
        end else if (stby_cmd) begin
            mode <= wwrc_pkg::WWRC_STANDBY;
        end
    end

    assign sleep_n_out = ~in_sleep;
    assign blocks_enable = (mode == wwrc_pkg::WWRC_RUN);

    // ************************************************************
    // data ready delay
    // ************************************************************
    // ready low while a startup or wake delay runs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ready_cnt <= W'(STARTUP);
        end else if (cmd.soft_reset) begin
            ready_cnt <= W'(STARTUP);
        end else if (wake_sleep) begin
            ready_cnt <= W'(SLEEP_WAKE);
        end else if (wake_stby) begin
            ready_cnt <= W'(STANDBY_WAKE);
        end else if (ready_cnt != '0) begin
            ready_cnt <= ready_cnt - W'(1);
        end
    end

    assign data_ready_out = (ready_cnt == '0);

    // ************************************************************
    // status flags and reset cause
    // ************************************************************
    logic [7:0] next_flags; // flags after this cycle's events

    // power-on value: only the power-on cause bit is set
    localparam logic [7:0] WWRC_POR_FLAGS = wwrc_pkg::WWRC_FLAGS_RST
        | (8'h01 << wwrc_pkg::WWRC_FLAG_CAUSE_POR);

    // mode commands set their flags; invalid restart sets bit 7
    always_comb begin
        next_flags = status_flags;
        if (cmd.soft_reset) begin
            next_flags[wwrc_pkg::WWRC_FLAG_INVALID] = 1'b0;
            next_flags[wwrc_pkg::WWRC_FLAG_SLEEP] = 1'b0;
            next_flags[wwrc_pkg::WWRC_FLAG_STANDBY] = 1'b0;
        end
        if (sleep_win) begin
            next_flags[wwrc_pkg::WWRC_FLAG_SLEEP] = 1'b1;
            next_flags[wwrc_pkg::WWRC_FLAG_STANDBY] = 1'b0;
        end
        if (stby_win) begin
            next_flags[wwrc_pkg::WWRC_FLAG_STANDBY] = 1'b1;
            next_flags[wwrc_pkg::WWRC_FLAG_SLEEP] = 1'b0;
        end
        if (cmd.normal_run) begin
            next_flags[wwrc_pkg::WWRC_FLAG_SLEEP] = 1'b0;
            next_flags[wwrc_pkg::WWRC_FLAG_STANDBY] = 1'b0;
        end
        if (restart_bad) begin
            next_flags[wwrc_pkg::WWRC_FLAG_INVALID] = 1'b1;
        end
        if (wd_trip) begin
            next_flags[wwrc_pkg::WWRC_FLAG_CAUSE_WDT] = 1'b1;
            next_flags[wwrc_pkg::WWRC_FLAG_CAUSE_POR] = 1'b0;
        end
    end

    // cause bits 1 and 0 survive soft reset; power-on sets bit 0
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_flags <= WWRC_POR_FLAGS;
        end else begin
            status_flags <= next_flags;
        end
    end

    // ************************************************************
    // measurement, fault and user settings
    // ************************************************************
    // cleared by power-on, soft reset and end of read-out
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meas_data <= wwrc_pkg::WWRC_MEAS_RST;
        end else if (cmd.soft_reset || cmd.readout_done) begin
            meas_data <= wwrc_pkg::WWRC_MEAS_RST;
        end else if (meas_load) begin
            meas_data <= meas_in;
        end
    end

    // fault bits follow the monitors from the first edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fault_reg <= wwrc_pkg::WWRC_FAULT_RST;
        end else begin
            fault_reg <= voltage_err;
        end
    end

    // user settings reload on soft reset, untouched by modes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            user_settings <= wwrc_pkg::WWRC_USER_INIT;
        end else if (cmd.soft_reset) begin
            user_settings <= wwrc_pkg::WWRC_USER_INIT;
        end
    end

endmodule // wwrc_top

/* File: wwrc_pkg.sv */
// package of constants and types for the window watchdog and reset control
package wwrc_pkg;

    // ************************************************************
    // timing counts, in sys_clk cycles of 4 ns
    // ************************************************************
    localparam int unsigned WWRC_CNT_W = 24; // width of every interval counter
    localparam int unsigned WWRC_INIT_WINDOW = 2000; // initial open window
    localparam int unsigned WWRC_CLOSED_WINDOW = 1000; // closed window
    localparam int unsigned WWRC_OPEN_WINDOW = 1000; // later open windows
    localparam int unsigned WWRC_RESET_PULSE = 250; // host reset low time
    localparam int unsigned WWRC_STARTUP = 500; // ready delay after reset
    localparam int unsigned WWRC_SLEEP_WAKE = 400; // ready delay after sleep
    localparam int unsigned WWRC_STANDBY_WAKE = 100; // after standby

    // ************************************************************
    // status flag positions and reset values
    // ************************************************************
    localparam int unsigned WWRC_FLAG_INVALID = 7; // previous command invalid
    localparam int unsigned WWRC_FLAG_SLEEP = 4; // sleep entered
    localparam int unsigned WWRC_FLAG_STANDBY = 3; // standby entered
    localparam int unsigned WWRC_FLAG_CAUSE_WDT = 1; // last reset by watchdog
    localparam int unsigned WWRC_FLAG_CAUSE_POR = 0; // last reset by power-on
    localparam logic [7:0] WWRC_FLAGS_RST = 8'h00; // flags after reset, without the power-on cause bit
    localparam logic [7:0] WWRC_MEAS_RST = 8'h00; // measurement clear value
    localparam logic [7:0] WWRC_FAULT_RST = 8'h00; // fault clear value
    localparam logic [7:0] WWRC_USER_INIT = 8'hFF; // user settings init

    // ************************************************************
    // types
    // ************************************************************
    // operating modes, one-hot
    typedef enum logic [2:0] {
        WWRC_RUN = 3'b001,
        WWRC_STANDBY = 3'b010,
        WWRC_SLEEP = 3'b100
    } wwrc_mode_t;

    // watchdog window states, one-hot
    typedef enum logic [2:0] {
        WWRC_WD_INIT = 3'b001,
        WWRC_WD_CLOSED = 3'b010,
        WWRC_WD_OPEN = 3'b100
    } wwrc_wd_t;

    // decoded command strobes from the serial front end
    typedef struct packed {
        logic restart;
        logic soft_reset;
        logic normal_run;
        logic sleep_enter_variant_a;
        logic sleep_enter_variant_b;
        logic standby_enter_variant_a;
        logic standby_enter_variant_b;
        logic readout_done;
    } wwrc_cmd_t;

endpackage

/* File: wwrc_top_assertions.sv */
// port-level checker for the watchdog and reset controller
`timescale 1ns/10ps
module wwrc_top_assertions #(
    parameter int unsigned RESET_PULSE = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire wwrc_pkg::wwrc_cmd_t cmd,
    input wire logic meas_load,
    input wire logic [7:0] voltage_err,
    input wire logic cs_n_pin,
    input wire logic host_reset_out,
    input wire logic data_ready_out,
    input wire logic sleep_n_out,
    input wire logic miso_oe,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] meas_data,
    input wire logic [7:0] fault_reg,
    input wire logic [7:0] user_settings,
    input wire logic blocks_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ****
    // helpers
    // ****
    logic [15:0] low_cnt; // cycles the host reset has been low
    wire logic sleep_cmd; // either sleep variant
    wire logic mode_cmd; // any mode change
    assign sleep_cmd = cmd.sleep_enter_variant_a | cmd.sleep_enter_variant_b;
    assign mode_cmd = sleep_cmd | cmd.normal_run | cmd.standby_enter_variant_a
        | cmd.standby_enter_variant_b;
    // count the low time of the reset line
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= host_reset_out ? 16'h0000 : low_cnt + 16'h0001;
        end
    end
    // ****
    // assertions
    // ****
    a_pulse_length: assert property (
        $rose(host_reset_out) |-> low_cnt == 16'(RESET_PULSE))
        else $error("reset pulse length wrong");
    a_sleep_entry: assert property (
        sleep_cmd && !cmd.soft_reset && !cmd.normal_run
        |=> !sleep_n_out && status_flags[4] && !blocks_enable)
        else $error("sleep entry wrong");
    a_run_wake: assert property (
        cmd.normal_run |=> sleep_n_out && blocks_enable && !status_flags[4])
        else $error("wake to run wrong");
    a_sleep_restart: assert property (
        cmd.restart && !sleep_n_out && !cmd.normal_run |=> status_flags[7])
        else $error("restart in sleep not flagged");
    a_miso_release: assert property (cs_n_pin [*4] |-> !miso_oe)
        else $error("miso driven while deselected");
    a_fault_follow: assert property (
        $past(rstn) |-> fault_reg == $past(voltage_err))
        else $error("fault register stale");
    a_readout_clear: assert property (
        cmd.readout_done && !meas_load |=> meas_data == 8'h00)
        else $error("measurement not cleared");
    a_soft_ready: assert property (
        cmd.soft_reset |=> (!data_ready_out) [*8])
        else $error("ready high too soon");
    a_mode_user: assert property (
        mode_cmd && !cmd.soft_reset |=> $stable(user_settings))
        else $error("user settings changed");
    c_trip: cover property ($fell(host_reset_out));
    c_sleep_restart: cover property (cmd.restart && !sleep_n_out);
    c_ready: cover property ($rose(data_ready_out));
endmodule // wwrc_top_assertions

bind wwrc_top wwrc_top_assertions #(.RESET_PULSE(RESET_PULSE)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .cmd(cmd), .meas_load(meas_load),
    .voltage_err(voltage_err), .cs_n_pin(cs_n_pin),
    .host_reset_out(host_reset_out), .data_ready_out(data_ready_out),
    .sleep_n_out(sleep_n_out), .miso_oe(miso_oe),
    .status_flags(status_flags), .meas_data(meas_data),
    .fault_reg(fault_reg), .user_settings(user_settings),
    .blocks_enable(blocks_enable));

/* File: wwrc_host_model.sv */
// host side model: chip-select frames paced by a 125 ns link clock
`timescale 1ns/10ps
module wwrc_host_model (
    input wire logic go,
    output logic cs_n,
    output logic miso_bit,
    output logic busy
);
    logic link_clk; // runs only inside a frame
    initial begin
        cs_n = 1'b1;
        miso_bit = 1'b0;
        busy = 1'b0;
        link_clk = 1'b0;
        #0.25;
        // between frames the data line wanders, never a stale value
        forever #62.5 if (!busy) miso_bit = ~miso_bit;
    end
    // one two-bit frame on each rising edge of go
    always @(posedge go) begin
        busy = 1'b1;
        cs_n = 1'b0;
        repeat (2) begin
            miso_bit = 1'($urandom);
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
        cs_n = 1'b1;
        busy = 1'b0;
    end
endmodule // wwrc_host_model

/* File: wwrc_top_tb.sv */
// self-checking bench for the watchdog and reset controller
`timescale 1ns/10ps
module wwrc_top_tb;
    localparam int INIT = 80;
    localparam int CLOSED = 20;
    localparam int OPEN = 20;
    localparam int STARTUP = 12;
    localparam int SLP = 16;
    localparam int STB = 9;
    logic sys_clk, rstn, meas_load, go, prev_hr, prev_dr, miso_o, miso_oe;
    logic host_reset_out, data_ready_out, sleep_n_out, blocks_enable;
    logic cs_n_pin, miso_data, link_busy;
    wwrc_pkg::wwrc_cmd_t cmd;
    logic [7:0] meas_in, voltage_err, v, status_flags, meas_data;
    logic [7:0] fault_reg, user_settings;
    int errors, n_compared, cyc, tk, kr;
    int fall_q[$], rise_q[$]; // expected cycles of reset falls, ready rises
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    wwrc_top #(.INIT_WINDOW(INIT), .CLOSED_WINDOW(CLOSED), .OPEN_WINDOW(OPEN),
        .RESET_PULSE(8), .STARTUP(STARTUP), .SLEEP_WAKE(SLP),
        .STANDBY_WAKE(STB)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .cmd(cmd), .meas_in(meas_in),
        .meas_load(meas_load), .voltage_err(voltage_err),
        .cs_n_pin(cs_n_pin), .miso_data(miso_data),
        .host_reset_out(host_reset_out), .data_ready_out(data_ready_out),
        .sleep_n_out(sleep_n_out), .miso_o(miso_o), .miso_oe(miso_oe),
        .status_flags(status_flags), .meas_data(meas_data),
        .fault_reg(fault_reg), .user_settings(user_settings),
        .blocks_enable(blocks_enable));
    wwrc_host_model u_host (.go(go), .cs_n(cs_n_pin), .miso_bit(miso_data),
        .busy(link_busy));
    task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (e !== g) begin
            errors++;
            $display("[FAIL] %0t exp=%0h got=%0h", $time, e, g);
        end
    endtask
    // event cycles must match the noted cycle exactly
    task automatic cmp_cyc(input int e, input int g);
        n_compared++;
        if (g != e) begin
            errors++;
            $display("[FAIL] %0t exp=%0h got=%0h", $time, e, g);
        end
    endtask
    task automatic send(input logic [7:0] c);
        cmd = wwrc_pkg::wwrc_cmd_t'(c);
        @(posedge sys_clk);
        tk = cyc;
        #1 cmd = '0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****
    // monitor: pops the oldest note when an event shows
    // ****
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rstn && prev_hr && host_reset_out === 1'b0) begin
            cmp_cyc(fall_q.size() ? fall_q.pop_front() : -99, cyc);
        end
        if (rstn && !prev_dr && data_ready_out === 1'b1) begin
            cmp_cyc(rise_q.size() ? rise_q.pop_front() : -99, cyc);
        end
        prev_hr <= host_reset_out;
        prev_dr <= data_ready_out;
        if (cyc > 2000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h7AC3));
        {rstn, meas_load, go, prev_dr, errors, n_compared, cyc} = '0;
        {cmd, meas_in, voltage_err} = '0;
        prev_hr = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1 rstn = 1'b1;
        rise_q.push_back(cyc + STARTUP);
        cmp8(8'h01, status_flags);
        cmp8(wwrc_pkg::WWRC_USER_INIT, user_settings);
        cmp8(8'h05, {5'h00, host_reset_out, data_ready_out, sleep_n_out});
        idle(5);
        send(8'h80);
        idle(3);
        fall_q.push_back(cyc + 1);
        send(8'h80);
        idle(12);
        cmp8(8'h02, status_flags);
        for (int i = 0; i < 4; i++) begin
            send(8'h02 << i);
            cmp8({4'h0, i > 1, i < 2, i < 2, 1'b0},
                {4'h0, status_flags[4:3], sleep_n_out, blocks_enable});
            if (i == 2) send(8'h80);
            if (i == 3) idle(INIT);
            send(8'h20);
            rise_q.push_back(tk + (i > 1 ? SLP : STB) + 1);
            idle((i > 1 ? SLP : STB) + 4);
        end
        fall_q.push_back(tk + INIT + 1);
        v = 8'($urandom);
        {voltage_err, meas_in, meas_load} = {v, ~v, 1'b1};
        idle(1);
        meas_load = 1'b0;
        idle(1);
        cmp8(v, fault_reg);
        cmp8(~v, meas_data);
        send(8'h01);
        cmp8(8'h00, meas_data);
        go = 1'b1;
        idle(8);
        cmp8(8'h01, {7'h00, miso_oe});
        while (link_busy) idle(1);
        go = 1'b0;
        idle(4);
        cmp8(8'h00, {6'h00, miso_o, miso_oe});
        cmp8(8'h82, status_flags);
        send(8'h80);
        kr = tk;
        idle(4);
        send(8'h40);
        rise_q.push_back(tk + STARTUP + 1);
        cmp8(8'h02, status_flags);
        cmp8(8'h05, {5'h00, host_reset_out, data_ready_out, sleep_n_out});
        fall_q.push_back(kr + CLOSED + OPEN + 1);
        idle(CLOSED + OPEN + 14);
        send(8'h80);
        idle(CLOSED + 5);
        send(8'h80);
        fall_q.push_back(tk + CLOSED + OPEN + 1);
        idle(CLOSED + OPEN + 12);
        cmp8(8'h00, 8'(fall_q.size() + rise_q.size()));
        report_and_stop();
    end
endmodule // wwrc_top_tb
